// ==== rtl/icf_top.sv ====
// interrupt control, trap status and request flag registers
// assumes sources give one-cycle pulses, ext pins synchronous to mclk
//
// Summary of operation
// - extension bit reads 1 when cpu level is above 7, else 0
// - cpu level is extension bit above the three status priority bits
// - cpu control reserved bit 2 reads 1, unimplemented bits read 0
// - unimplemented bits in control and flag registers always read 0
// - four trap flags at bits 4..1 set on trap, reset to 0
// - control two bit 15 selects alternate vector table, resets 0
// - control two bit 14 read-only, follows timed disable activity
// - ext irq polarity bits 0..4: 1 negative edge, 0 positive edge
// - request flags read 1 after request, software writable, reset 0
// - flag register zero layout bits 0..14, bit 15 unused
// - flag register one layout, bit 5 unused
// - flag register two layout, bits 2,3,15 unused
// - flags set by sources, cleared only by software write
// - nesting disabled makes status priority bits read-only
// - status priority bits 111 block all user requests
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "icf_regs.svh"
module icf_top #(
  parameter int NSRC = 48
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // register port
  input  wire icf_pkg::icf_bus_type bus,
  output logic [15:0]               rdata,
  // cpu core side
  input  wire icf_pkg::icf_core_type core,
  output logic                      irq_req,
  output logic [3:0]                cpu_level,
  output logic                      alternate_table_select,
  output logic                      nesting_disable,
  output logic                      irq_out,
  // request sources
  input  wire logic [NSRC-1:0]      src_pulse,
  input  wire logic [4:0]           ext_pin
);
  import icf_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [2:0]        cpu_priority_bits_reg;
  logic              priority_extension_bit_reg;
  logic [15:0]       ctl1_reg;
  logic [15:0]       ctl2_reg;
  logic [15:0]       flg_reg [3];
  logic [15:0]       en_reg [3];
  logic [2:0]        prio_reg;
  logic [4:0]        ext_prev_reg;
  logic [2:0]        ev_st_reg;
  logic [2:0]        ev_en_reg;
  logic [15:0]       rdata_next;
  logic [15:0]       fmask [3];
  logic [15:0]       set_vec [3];
  logic [4:0]        ext_edge;
  logic [3:0]        level;
  logic              pend;
  logic [2:0]        ev_pulse;
  icf_state_type     state_reg;

  assign fmask[0] = `ICF_MASK_FLG0;
  assign fmask[1] = `ICF_MASK_FLG1;
  assign fmask[2] = `ICF_MASK_FLG2;
  assign level = {priority_extension_bit_reg, cpu_priority_bits_reg};

  // ****************************************
  // external edge detect
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      ext_prev_reg <= 5'h00;
    else
      ext_prev_reg <= ext_pin;

  generate
    for (genvar i = 0; i < 5; i++)
    begin : g_edge
      assign ext_edge[i] = ctl2_reg[i] ? (ext_prev_reg[i] & ~ext_pin[i])
                                       : (~ext_prev_reg[i] & ext_pin[i]);
    end
  endgenerate

  // sources: index 0 ext0, 20 ext1, 29 ext2; rest from src_pulse by position
  always_comb
  begin
    set_vec[0] = src_pulse[15:0];
    set_vec[1] = src_pulse[31:16];
    set_vec[2] = src_pulse[47:32];
    set_vec[0][0] = ext_edge[0];
    set_vec[1][4] = ext_edge[1];
    set_vec[1][13] = ext_edge[2];
  end

  // ****************************************
  // cpu priority and control
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      cpu_priority_bits_reg <= `ICF_RST_IPL;
    else if (bus.wr && bus.addr == `ICF_OFF_SR && !ctl1_reg[`ICF_CTL1_NEST])
      cpu_priority_bits_reg <= bus.wdata[`ICF_SR_IPL_LO+2:`ICF_SR_IPL_LO];

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      priority_extension_bit_reg <= 1'b0;
    else
      priority_extension_bit_reg <= core.ext_hold;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      ctl1_reg <= `ICF_RST_WORD;
    else
    begin
      if (bus.wr && bus.addr == `ICF_OFF_CTL1)
        ctl1_reg <= bus.wdata & `ICF_MASK_CTL1;
      if (core.trap != 4'h0)
        ctl1_reg[4:1] <= ((bus.wr && bus.addr == `ICF_OFF_CTL1) ? bus.wdata[4:1] : ctl1_reg[4:1])
                         | core.trap;
    end

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      ctl2_reg <= `ICF_RST_WORD;
    else
    begin
      if (bus.wr && bus.addr == `ICF_OFF_CTL2)
      begin
        ctl2_reg[`ICF_CTL2_ALT] <= bus.wdata[`ICF_CTL2_ALT];
        ctl2_reg[4:0] <= bus.wdata[4:0];
      end
      ctl2_reg[`ICF_CTL2_DIS] <= core.timed_irq_disable_active_active;
    end

  // ****************************************
  // request flags and enables
  // ****************************************
  generate
    for (genvar r = 0; r < 3; r++)
    begin : g_flag
      always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
          flg_reg[r] <= `ICF_RST_WORD;
        else if (bus.wr && bus.addr == 4'(`ICF_OFF_FLG0 + r))
          flg_reg[r] <= (bus.wdata | set_vec[r]) & fmask[r];
        else
          flg_reg[r] <= (flg_reg[r] | set_vec[r]) & fmask[r];

      always_ff @(posedge mclk or posedge sys_rst)
        if (sys_rst)
          en_reg[r] <= `ICF_RST_WORD;
        else if (bus.wr && bus.addr == 4'(`ICF_OFF_EN0 + r))
          en_reg[r] <= bus.wdata & fmask[r];
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      prio_reg <= 3'h0;
    else if (bus.wr && bus.addr == `ICF_OFF_PRIO)
      prio_reg <= bus.wdata[2:0];

  // ****************************************
  // pending request
  // ****************************************
  assign pend = (|((flg_reg[0] & en_reg[0]) | (flg_reg[1] & en_reg[1]) | (flg_reg[2] & en_reg[2])))
                && cpu_priority_bits_reg != `ICF_IPL_TOP
                && {1'b0, prio_reg} > level;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      state_reg <= ICF_IDLE;
    else
      case (state_reg)
        ICF_IDLE: if (pend) state_reg <= ICF_PEND;
        ICF_PEND: if (!pend) state_reg <= ICF_IDLE;
        default:  state_reg <= ICF_IDLE;
      endcase

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      irq_req <= 1'b0;
    else
      irq_req <= pend;

  // ****************************************
  // event status: trap, request rise, fall
  // ****************************************
  assign ev_pulse = {state_reg == ICF_PEND && !pend, state_reg == ICF_IDLE && pend, core.trap != 4'h0};

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      ev_st_reg <= 3'h0;
    else if (bus.wr && bus.addr == `ICF_OFF_EVCLR)
      ev_st_reg <= (ev_st_reg & ~bus.wdata[2:0]) | ev_pulse;
    else
      ev_st_reg <= ev_st_reg | ev_pulse;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      ev_en_reg <= 3'h0;
    else if (bus.wr && bus.addr == `ICF_OFF_EVEN)
      ev_en_reg <= bus.wdata[2:0];

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      irq_out <= 1'b0;
    else
      irq_out <= |(ev_st_reg & ev_en_reg);

  // ****************************************
  // outputs to core
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      cpu_level <= 4'h0;
      alternate_table_select <= 1'b0;
      nesting_disable <= 1'b0;
    end
    else
    begin
      cpu_level <= level;
      alternate_table_select <= ctl2_reg[`ICF_CTL2_ALT];
      nesting_disable <= ctl1_reg[`ICF_CTL1_NEST];
    end

  // ****************************************
  // read decode
  // ****************************************
  always_comb
  begin
    rdata_next = 16'h0000;
    if (bus.addr == `ICF_OFF_SR)
      rdata_next[`ICF_SR_IPL_LO+2:`ICF_SR_IPL_LO] = cpu_priority_bits_reg;
    else if (bus.addr == `ICF_OFF_CORE)
    begin
      rdata_next[`ICF_CORE_EXT] = priority_extension_bit_reg;
      rdata_next[`ICF_CORE_RSVD] = 1'b1;
    end
    else if (bus.addr == `ICF_OFF_CTL1)
      rdata_next = ctl1_reg & `ICF_MASK_CTL1;
    else if (bus.addr == `ICF_OFF_CTL2)
      rdata_next = ctl2_reg & 16'hc01f;
    else if (bus.addr == `ICF_OFF_FLG0)
      rdata_next = flg_reg[0];
    else if (bus.addr == `ICF_OFF_FLG1)
      rdata_next = flg_reg[1];
    else if (bus.addr == `ICF_OFF_FLG2)
      rdata_next = flg_reg[2];
    else if (bus.addr == `ICF_OFF_EN0)
      rdata_next = en_reg[0];
    else if (bus.addr == `ICF_OFF_EN1)
      rdata_next = en_reg[1];
    else if (bus.addr == `ICF_OFF_EN2)
      rdata_next = en_reg[2];
    else if (bus.addr == `ICF_OFF_PRIO)
      rdata_next[2:0] = prio_reg;
    else if (bus.addr == `ICF_OFF_EVST)
      rdata_next[2:0] = ev_st_reg;
    else if (bus.addr == `ICF_OFF_EVEN)
      rdata_next[2:0] = ev_en_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      rdata <= 16'h0000;
    else if (bus.rd)
      rdata <= rdata_next;
    else
      rdata <= 16'h0000;
endmodule

// ==== rtl/icf_regs.svh ====
// register offsets, field positions, reset values for the interrupt control and flag block
// assumes inclusion by the top module and the property checker only
`ifndef ICF_REGS_SVH
`define ICF_REGS_SVH
// ****************************************
// register offsets (word index on the plain port)
// ****************************************
`define ICF_OFF_SR        4'h0
`define ICF_OFF_CORE      4'h1
`define ICF_OFF_CTL1      4'h2
`define ICF_OFF_CTL2      4'h3
`define ICF_OFF_FLG0      4'h4
`define ICF_OFF_FLG1      4'h5
`define ICF_OFF_FLG2      4'h6
`define ICF_OFF_EN0       4'h7
`define ICF_OFF_EN1       4'h8
`define ICF_OFF_EN2       4'h9
`define ICF_OFF_PRIO      4'ha
`define ICF_OFF_EVST      4'hb
`define ICF_OFF_EVCLR     4'hc
`define ICF_OFF_EVEN      4'hd
// ****************************************
// field positions
// ****************************************
`define ICF_SR_IPL_LO     5
`define ICF_CORE_EXT      3
`define ICF_CORE_RSVD     2
`define ICF_CTL1_NEST     15
`define ICF_CTL2_ALT      15
`define ICF_CTL2_DIS      14
// ****************************************
// implemented bit masks, reset values
// ****************************************
`define ICF_MASK_CTL1     16'h801e
`define ICF_MASK_CTL2     16'h801f
`define ICF_MASK_FLG0     16'h7fff
`define ICF_MASK_FLG1     16'hffdf
`define ICF_MASK_FLG2     16'h7ff3
`define ICF_RST_WORD      16'h0000
`define ICF_RST_IPL       3'h0
`define ICF_IPL_TOP       3'h7
`endif

// ==== rtl/icf_pkg.sv ====
// types shared by the interrupt control and flag block
// assumes icf_regs.svh holds all numbers
package icf_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } icf_bus_type;
  typedef struct packed {
    logic [3:0] trap;
    logic       ext_hold;
    logic       timed_irq_disable_active_active;
  } icf_core_type;
  typedef enum logic [1:0] {
    ICF_IDLE = 2'b01,
    ICF_PEND = 2'b10
  } icf_state_type;
endpackage

// ==== test/icf_top_properties.sv ====
// concurrent checks on the interrupt control and flag block
// assumes one clock domain, bound to icf_top
`timescale 1ns/100ps
`include "icf_regs.svh"
module icf_checker #(
  parameter int NSRC = 48
) (
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // register port
  input wire icf_pkg::icf_bus_type  bus,
  input wire logic [15:0]           rdata,
  // core side
  input wire icf_pkg::icf_core_type core,
  input wire logic                  irq_req,
  input wire logic [3:0]            cpu_level,
  input wire logic                  alternate_table_select,
  input wire logic                  nesting_disable,
  input wire logic                  irq_out,
  // sources
  input wire logic [NSRC-1:0]       src_pulse,
  input wire logic [4:0]            ext_pin
);
  import icf_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  core_rsvd_a: assert property ($past(bus.rd) && $past(bus.addr) == 4'h1 |->
    rdata[2] && rdata[15:4] == 12'h0 && rdata[1:0] == 2'h0) else $error("cpu control read wrong");
  ext_level_a: assert property ($past(core.ext_hold, 2) == $past(core.ext_hold) |->
    cpu_level[3] == $past(core.ext_hold)) else $error("extension bit wrong");
  ctl_unused_a: assert property ($past(bus.rd) && $past(bus.addr) == 4'h2 |->
    (rdata & ~`ICF_MASK_CTL1) == 16'h0) else $error("control one unused bit set");
  flag_one_unused_a: assert property ($past(bus.rd) && $past(bus.addr) == 4'h5 |->
    rdata[5] == 1'b0) else $error("flag one bit 5 set");
  timed_irq_disable_active_follow_a: assert property ($past(bus.rd) && $past(bus.addr) == 4'h3 &&
    $past(core.timed_irq_disable_active_active, 2) == $past(core.timed_irq_disable_active_active, 3) |-> rdata[14] == $past(core.timed_irq_disable_active_active, 2))
    else $error("timed disable bit wrong");
  top_block_a: assert property (cpu_level[2:0] == 3'h7 [*2] |-> !irq_req)
    else $error("request at level 7");
  nest_freeze_a: assert property (nesting_disable && !$past(bus.wr && bus.addr == 4'h2) &&
    bus.wr && bus.addr == 4'h0 |-> ##2 $stable(cpu_level[2:0])) else $error("priority written while frozen");
  alt_hold_a: assert property (!(bus.wr && bus.addr == 4'h3) |-> ##2
    $stable(alternate_table_select)) else $error("table select changed");
  nest_hold_a: assert property (!(bus.wr && bus.addr == 4'h2) |-> ##2
    $stable(nesting_disable)) else $error("nesting control changed");
endmodule
bind icf_top icf_checker #(.NSRC(NSRC)) chk_i (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
  .core(core), .irq_req(irq_req), .cpu_level(cpu_level), .alternate_table_select(alternate_table_select),
  .nesting_disable(nesting_disable), .irq_out(irq_out), .src_pulse(src_pulse), .ext_pin(ext_pin));

// ==== test/icf_core_model.sv ====
// model of the cpu core and the request sources
// assumes the bench calls its tasks, one clock
`timescale 1ns/100ps
module icf_core_model (
  // clock
  input wire logic        mclk,
  // core and sources
  output icf_pkg::icf_core_type core,
  output logic [47:0]     src_pulse,
  output logic [4:0]      ext_pin
);
  import icf_pkg::*;
  // ****************************************
  // stimulus tasks
  // ****************************************
  initial
  begin
    core = '0;
    src_pulse = '0;
    ext_pin = '0;
  end
  task automatic trap(input logic [3:0] t);
    @(posedge mclk);
    core.trap <= t;
    @(posedge mclk);
    core.trap <= 4'h0;
  endtask
  // sources only set, never clear
  task automatic src(input logic [47:0] s);
    @(posedge mclk);
    src_pulse <= s;
    @(posedge mclk);
    src_pulse <= '0;
  endtask
  task automatic lvl(input logic h, input logic d, input logic [4:0] p);
    @(posedge mclk);
    core.ext_hold <= h;
    core.timed_irq_disable_active_active <= d;
    ext_pin <= p;
  endtask
endmodule

// ==== test/icf_top_test.sv ====
// self-checking bench for the interrupt control and flag block
// assumes the core model drives core and sources
`timescale 1ns/100ps
module icf_top_test;
  import icf_pkg::*;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  icf_bus_type  bus = '0;
  logic [15:0]  rdata;
  icf_core_type core;
  logic         irq_req, irq_out, alt_sel, nest_dis, rd_seen = 1'b0;
  logic [3:0]   cpu_level;
  logic [47:0]  src_pulse, s;
  logic [4:0]   ext_pin;
  logic [15:0]  exp_q[$], seed = 16'h001c;
  logic [15:0]  msk[1:6] = '{16'h0004, 16'h801e, 16'h801f, 16'h7fff, 16'hffdf, 16'h7ff3};
  int           err_total = 0;
  int           n_tests = 0;
  always #2 mclk = ~mclk;
  icf_top dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .core(core), .irq_req(irq_req),
    .cpu_level(cpu_level), .alternate_table_select(alt_sel), .nesting_disable(nest_dis), .irq_out(irq_out),
    .src_pulse(src_pulse), .ext_pin(ext_pin));
  icf_core_model partner (.mclk(mclk), .core(core), .src_pulse(src_pulse), .ext_pin(ext_pin));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{a, d, w, ~w};
    @(posedge mclk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 16'h0);
  endtask
  task automatic wait_for(input logic sel, input logic e);
    int i;
    for (i = 0; i < 8 && (sel ? irq_out : irq_req) !== e; i++)
      @(negedge mclk);
    chk({15'h0, sel ? irq_out : irq_req}, {15'h0, e});
    if (i == 8)
      close_out();
  endtask
  always @(posedge mclk)
    rd_seen <= bus.rd;
  always @(negedge mclk)
    if (rd_seen)
      chk(rdata, exp_q.pop_front());
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++)
      rd(a[3:0], a == 1 ? 16'h0004 : 16'h0000);
    for (int a = 1; a < 7; a++)
    begin
      wr(a[3:0], 16'hffff);
      rd(a[3:0], msk[a]);
    end
    chk({14'h0, nest_dis, alt_sel}, 16'h0003);
    for (int a = 1; a < 7; a++)
    begin
      wr(a[3:0], 16'h0000);
      rd(a[3:0], msk[1] & {16{a == 1}});
    end
    wr(4'h0, 16'h00e0);
    rd(4'h0, 16'h00e0);
    chk({12'h0, cpu_level}, 16'h0007);
    wr(4'h2, 16'h8000);
    wr(4'h0, 16'h0020);
    rd(4'h0, 16'h00e0);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h0000);
    partner.trap(4'h9);
    rd(4'h2, 16'h0012);
    partner.lvl(1'b1, 1'b1, 5'h00);
    rd(4'h1, 16'h000c);
    rd(4'h3, 16'h4000);
    chk({12'h0, cpu_level}, 16'h0008);
    partner.lvl(1'b0, 1'b0, 5'h00);
    repeat (4)
    begin
      for (int k = 0; k < 3; k++)
      begin
        seed = lfsr(seed);
        s[k*16+:16] = seed;
      end
      partner.src(s);
      rd(4'h4, s[15:0] & 16'h7ffe);
      rd(4'h5, s[31:16] & 16'hdfcf);
      rd(4'h6, s[47:32] & 16'h7ff3);
      repeat (8) @(posedge mclk);
      rd(4'h6, s[47:32] & 16'h7ff3);
      for (int a = 4; a < 7; a++)
        wr(a[3:0], 16'h0000);
    end
    for (int p = 0; p < 2; p++)
    begin
      partner.lvl(1'b0, 1'b0, p ? 5'h00 : 5'h1f);
      rd(4'h4, 16'h0001);
      rd(4'h5, 16'h2010);
      wr(4'h3, p ? 16'h0000 : 16'h001f);
      wr(4'h4, 16'h0000);
      wr(4'h5, 16'h0000);
    end
    wr(4'hc, 16'h0007);
    rd(4'hb, 16'h0000);
    wr(4'h7, 16'h0002);
    wr(4'ha, 16'h0005);
    partner.src(48'h2);
    wait_for(1'b0, 1'b1);
    wr(4'h0, 16'h00c0);
    wait_for(1'b0, 1'b0);
    wr(4'h0, 16'h00e0);
    wait_for(1'b0, 1'b0);
    wr(4'h0, 16'h0080);
    wait_for(1'b0, 1'b1);
    rd(4'hb, 16'h0006);
    wr(4'hd, 16'h0002);
    wait_for(1'b1, 1'b1);
    wr(4'hd, 16'h0000);
    wait_for(1'b1, 1'b0);
    wr(4'hc, 16'h0006);
    rd(4'hb, 16'h0000);
    rd(4'hf, 16'h0000);
    repeat (2) @(posedge mclk);
    close_out();
  end
endmodule
